// [pkg/lpm_pkg.sv]
// Constants, modes and timing for the low-power and emulation mode controller.
// Assumes one 25 MHz clock and a core that retires one request strobe per cycle.
package lpm_pkg;

  // Clock and machine cycle
  localparam int CLK_MHZ          = 25;
  localparam int MACH_CYC_CLKS    = 12;
  localparam int RST_HOLD_MCYC    = 2;
  localparam int RST_HOLD_CLKS    = RST_HOLD_MCYC * MACH_CYC_CLKS;
  localparam int RST_CNT_W        = 5;

  // Oscillator restart time
  localparam int OSC_STABLE_MS    = 10;
  localparam int OSC_STABLE_CLKS  = OSC_STABLE_MS * CLK_MHZ * 1000;
  localparam int OSC_CNT_W        = 18;

  // Mode states, Gray along run, deep, restart, pin wait
  typedef enum logic [2:0] {
    ST_RUN   = 3'b000,
    ST_DEEP  = 3'b001,
    ST_OSCW  = 3'b011,
    ST_PINW  = 3'b010,
    ST_LIGHT = 3'b110,
    ST_EMUL  = 3'b100
  } lpm_state_t;

  // Cause of a deep sleep wake-up
  typedef enum logic {
    WAKE_BY_RST = 1'b0,
    WAKE_BY_IRQ = 1'b1
  } lpm_wake_t;

endpackage : lpm_pkg

// [rtl/lpm_rst_filter.sv]
// Reset pin qualifier: chip reset once the pin stays high two machine cycles.
// Assumes the pin is synchronous to ref_clk; counts only while the oscillator runs.
`timescale 1ns/1ns
module lpm_rst_filter
  import lpm_pkg::*;
(
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic clk_en,
  // Pin and oscillator
  input  wire logic rst_pin,
  input  wire logic osc_on,
  // Qualified reset
  output logic      chip_rst
);

  typedef struct packed {
    logic [RST_CNT_W-1:0] cnt;
    logic                 hit;
  } lpm_filt_t;

  lpm_filt_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    if (!rst_pin) begin
      s_d.cnt = '0;
      s_d.hit = 1'b0;
    end else if (osc_on && !s_q.hit) begin
      if (s_q.cnt == RST_CNT_W'(RST_HOLD_CLKS - 1)) begin
        s_d.hit = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + RST_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_q <= '0;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  assign chip_rst = s_q.hit;

endmodule : lpm_rst_filter

// [rtl/lpm_ctrl.sv]
// Light sleep, deep sleep and emulation mode control with pin state overrides.
// Assumes a core that obeys core_run, sfr_reinit and ram_block, and board pins
// resolved outside from the drive and enable outputs.
`timescale 1ns/1ns
module lpm_ctrl
  import lpm_pkg::*;
#(
  parameter int OSC_WAIT_CLKS = OSC_STABLE_CLKS
)(
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       clk_en,
  // Requests from the core
  input  wire logic       light_req,
  input  wire logic       deep_req,
  input  wire logic       irq_pending,
  input  wire logic       return_from_handler,
  // Core configuration
  input  wire logic       ext_code,
  input  wire logic       ale_disable,
  input  wire logic       ext_irq_a_en,
  input  wire logic       ext_irq_b_en,
  input  wire logic       ext_irq_a_level,
  input  wire logic       ext_irq_b_level,
  // Core pin functions in normal running
  input  wire logic       core_ale,
  input  wire logic       core_prog_store,
  input  wire logic       core_p2_addr,
  // Board pins
  input  wire logic       rst_pin,
  input  wire logic       ext_irq_a_n,
  input  wire logic       ext_irq_b_n,
  input  wire logic       ale_pin_in,
  input  wire logic       prog_store_strobe_in,
  // Core control
  output logic            core_run,
  output logic            osc_run,
  output logic            chip_reset,
  output logic            sfr_reinit,
  output logic            ram_block,
  output logic            wake_irq,
  output logic            resume_next,
  // Mode status
  output logic            light_sleep,
  output logic            deep_sleep,
  output logic            emul_mode,
  // Pin drive
  output logic            ale_out,
  output logic            ale_oe,
  output logic            ale_weak_pu,
  output logic            prog_store_strobe_out,
  output logic            prog_store_strobe_oe,
  output logic            prog_store_strobe_weak_pu,
  output logic            port0_float,
  output logic            port2_addr_sel,
  output logic            port_weak_pu
);

  typedef struct packed {
    lpm_state_t           st;
    lpm_wake_t            why;
    logic [OSC_CNT_W-1:0] cnt;
    logic                 strap;
    logic                 in_rst;
    logic                 light_rst;
    logic                 deep_wake;
    logic                 core_run;
    logic                 osc_run;
    logic                 sfr_reinit;
    logic                 ram_block;
    logic                 wake_irq;
    logic                 resume_next;
    logic                 ale_out;
    logic                 ale_oe;
    logic                 ale_weak_pu;
    logic                 ps_out;
    logic                 ps_oe;
    logic                 ps_weak_pu;
    logic                 p0_float;
    logic                 p2_addr;
    logic                 port_weak_pu;
    logic                 lt_mode;
    logic                 dp_mode;
    logic                 em_mode;
  } lpm_ctrl_t;

  lpm_ctrl_t s_q, s_d;
  logic      chip_rst;
  logic      irq_a_wake;
  logic      irq_b_wake;
  logic      irq_low;

  // Two machine cycle reset qualifier
  lpm_rst_filter u_rst_filter (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .clk_en   (clk_en),
    .rst_pin  (rst_pin),
    .osc_on   (s_q.osc_run),
    .chip_rst (chip_rst)
  );

  assign irq_a_wake = ext_irq_a_en && ext_irq_a_level && !ext_irq_a_n;
  assign irq_b_wake = ext_irq_b_en && ext_irq_b_level && !ext_irq_b_n;
  assign irq_low    = irq_a_wake || irq_b_wake;

  always_comb begin
    s_d             = s_q;
    s_d.sfr_reinit  = 1'b0;
    s_d.wake_irq    = 1'b0;
    s_d.resume_next = 1'b0;
    s_d.in_rst      = chip_rst;

    if (chip_rst) begin
      // Chip reset: hold core, reinitialise registers, watch the strap
      s_d.st        = ST_RUN;
      s_d.core_run  = 1'b0;
      s_d.osc_run   = 1'b1;
      s_d.sfr_reinit = 1'b1;
      s_d.ram_block = 1'b0;
      s_d.light_rst = 1'b0;
      s_d.deep_wake = 1'b0;
      s_d.cnt       = '0;
      if (!ale_pin_in && prog_store_strobe_in) begin
        s_d.strap = 1'b1;
      end
    end else if (s_q.in_rst) begin
      // Release of reset: strap still low selects emulation
      s_d.core_run = 1'b1;
      if (s_q.strap && !ale_pin_in) begin
        s_d.st       = ST_EMUL;
        s_d.core_run = 1'b0;
      end
      s_d.strap = 1'b0;
    end else begin
      unique case (s_q.st)
        ST_RUN: begin
          if (s_q.light_rst) begin
            s_d.ram_block = 1'b1;
          end else if (deep_req) begin
            s_d.st       = ST_DEEP;
            s_d.core_run = 1'b0;
            s_d.osc_run  = 1'b0;
          end else if (light_req) begin
            s_d.st       = ST_LIGHT;
            s_d.core_run = 1'b0;
          end
          if (return_from_handler && s_q.deep_wake) begin
            s_d.resume_next = 1'b1;
            s_d.deep_wake   = 1'b0;
          end
        end
        ST_LIGHT: begin
          if (rst_pin) begin
            s_d.st        = ST_RUN;
            s_d.core_run  = 1'b1;
            s_d.ram_block = 1'b1;
            s_d.light_rst = 1'b1;
          end else if (irq_pending) begin
            s_d.st       = ST_RUN;
            s_d.core_run = 1'b1;
          end
        end
        ST_DEEP: begin
          // Nothing changes until a waking source appears
          if (rst_pin || irq_low) begin
            s_d.st      = ST_OSCW;
            s_d.osc_run = 1'b1;
            s_d.cnt     = '0;
            s_d.why     = rst_pin ? WAKE_BY_RST : WAKE_BY_IRQ;
          end
        end
        ST_OSCW: begin
          if (s_q.cnt == OSC_CNT_W'(OSC_WAIT_CLKS - 1)) begin
            s_d.st = ST_PINW;
          end else begin
            s_d.cnt = s_q.cnt + OSC_CNT_W'(1);
          end
        end
        ST_PINW: begin
          if (s_q.why == WAKE_BY_IRQ && !irq_low) begin
            s_d.st        = ST_RUN;
            s_d.core_run  = 1'b1;
            s_d.wake_irq  = 1'b1;
            s_d.deep_wake = 1'b1;
          end else if (s_q.why == WAKE_BY_RST && !rst_pin) begin
            s_d.st      = ST_DEEP;
            s_d.osc_run = 1'b0;
          end
        end
        ST_EMUL: begin
          s_d.core_run = 1'b0;
          s_d.osc_run  = 1'b1;
        end
        default: begin
          s_d.st       = ST_RUN;
          s_d.core_run = 1'b1;
          s_d.osc_run  = 1'b1;
        end
      endcase
    end

    // Pin states follow the next mode
    s_d.ale_weak_pu  = 1'b0;
    s_d.ps_weak_pu   = 1'b0;
    s_d.port_weak_pu = 1'b0;
    s_d.p0_float     = 1'b0;
    s_d.p2_addr      = 1'b0;
    if (chip_rst) begin
      s_d.ale_out     = 1'b1;
      s_d.ale_oe      = 1'b0;
      s_d.ale_weak_pu = 1'b1;
      s_d.ps_out      = 1'b1;
      s_d.ps_oe       = 1'b1;
    end else begin
      unique case (s_d.st)
        ST_LIGHT: begin
          s_d.ale_out  = 1'b1;
          s_d.ale_oe   = 1'b1;
          s_d.ps_out   = 1'b1;
          s_d.ps_oe    = 1'b1;
          s_d.p0_float = ext_code;
          s_d.p2_addr  = ext_code;
        end
        ST_EMUL: begin
          s_d.ale_out      = 1'b1;
          s_d.ale_oe       = 1'b0;
          s_d.ale_weak_pu  = 1'b1;
          s_d.ps_out       = 1'b1;
          s_d.ps_oe        = 1'b0;
          s_d.ps_weak_pu   = 1'b1;
          s_d.p0_float     = 1'b1;
          s_d.port_weak_pu = 1'b1;
        end
        ST_RUN: begin
          s_d.ale_out = core_ale;
          s_d.ps_out  = core_prog_store;
          s_d.ps_oe   = 1'b1;
          s_d.p2_addr = core_p2_addr;
          if (ale_disable && !ext_code) begin
            s_d.ale_oe      = 1'b0;
            s_d.ale_weak_pu = 1'b1;
          end else begin
            s_d.ale_oe = 1'b1;
          end
        end
        default: begin
          // Deep sleep and its wake-up steps
          s_d.ale_out  = 1'b0;
          s_d.ale_oe   = 1'b1;
          s_d.ps_out   = 1'b0;
          s_d.ps_oe    = 1'b1;
          s_d.p0_float = ext_code;
        end
      endcase
    end

    // Mode status registered so the outputs come from flip-flops
    s_d.lt_mode = (s_d.st == ST_LIGHT);
    s_d.dp_mode = (s_d.st == ST_DEEP) || (s_d.st == ST_OSCW) || (s_d.st == ST_PINW);
    s_d.em_mode = (s_d.st == ST_EMUL);
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_q          <= '0;
      s_q.st       <= ST_RUN;
      s_q.why      <= WAKE_BY_RST;
      s_q.core_run <= 1'b1;
      s_q.osc_run  <= 1'b1;
      s_q.ale_out  <= 1'b1;
      s_q.ale_oe   <= 1'b1;
      s_q.ps_out   <= 1'b1;
      s_q.ps_oe    <= 1'b1;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register
  assign core_run                  = s_q.core_run;
  assign osc_run                   = s_q.osc_run;
  assign chip_reset                = s_q.in_rst;
  assign sfr_reinit                = s_q.sfr_reinit;
  assign ram_block                 = s_q.ram_block;
  assign wake_irq                  = s_q.wake_irq;
  assign resume_next               = s_q.resume_next;
  assign light_sleep               = s_q.lt_mode;
  assign deep_sleep                = s_q.dp_mode;
  assign emul_mode                 = s_q.em_mode;
  assign ale_out                   = s_q.ale_out;
  assign ale_oe                    = s_q.ale_oe;
  assign ale_weak_pu               = s_q.ale_weak_pu;
  assign prog_store_strobe_out     = s_q.ps_out;
  assign prog_store_strobe_oe      = s_q.ps_oe;
  assign prog_store_strobe_weak_pu = s_q.ps_weak_pu;
  assign port0_float               = s_q.p0_float;
  assign port2_addr_sel            = s_q.p2_addr;
  assign port_weak_pu              = s_q.port_weak_pu;

endmodule : lpm_ctrl

// [verif/lpm_ctrl_asserts.sv]
// Checker of mode and pin relations at the controller ports.
// Bound to lpm_ctrl; one clock, synchronous active high reset.
`timescale 1ns/1ns
module lpm_ctrl_asserts
  import lpm_pkg::*;
(
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic clk_en,
  // Inputs
  input  wire logic light_req,
  input  wire logic deep_req,
  input  wire logic irq_pending,
  input  wire logic ext_code,
  input  wire logic rst_pin,
  // Outputs
  input  wire logic core_run,
  input  wire logic osc_run,
  input  wire logic chip_reset,
  input  wire logic sfr_reinit,
  input  wire logic ram_block,
  input  wire logic wake_irq,
  input  wire logic light_sleep,
  input  wire logic deep_sleep,
  input  wire logic emul_mode,
  input  wire logic ale_out,
  input  wire logic ale_oe,
  input  wire logic ale_weak_pu,
  input  wire logic prog_store_strobe_out,
  input  wire logic prog_store_strobe_oe,
  input  wire logic port0_float,
  input  wire logic port2_addr_sel,
  input  wire logic port_weak_pu
);
  logic [5:0] hold_q;
  logic       run_st;
  assign run_st = core_run && !light_sleep && !deep_sleep && !emul_mode && !chip_reset && clk_en
    && !ram_block && !rst_pin;
  // Consecutive cycles of reset pin high with oscillator on
  always_ff @(posedge ref_clk) begin
    if (rst || !rst_pin || !osc_run) hold_q <= 6'h00;
    else if (clk_en && hold_q != 6'h3f) hold_q <= hold_q + 6'h01;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  property p_deep_wins;
    run_st && deep_req && light_req |=> deep_sleep && !light_sleep;
  endproperty
  a_deep_wins: assert property (p_deep_wins) else $error("deep request lost");
  property p_deep_stop;
    run_st && deep_req |=> deep_sleep && !core_run && !osc_run;
  endproperty
  a_deep_stop: assert property (p_deep_stop) else $error("deep entry wrong");
  property p_light_pins;
    light_sleep |-> !core_run && osc_run && ale_out && prog_store_strobe_out && !ale_weak_pu
      && port0_float == ext_code && port2_addr_sel == ext_code;
  endproperty
  a_light_pins: assert property (p_light_pins) else $error("light pins wrong");
  property p_deep_pins;
    deep_sleep && !chip_reset |-> !ale_out && !prog_store_strobe_out && !ale_weak_pu
      && !port2_addr_sel && port0_float == ext_code && !core_run && !sfr_reinit;
  endproperty
  a_deep_pins: assert property (p_deep_pins) else $error("deep pins wrong");
  property p_light_wake;
    light_sleep && irq_pending && !rst_pin |=> core_run && !light_sleep;
  endproperty
  a_light_wake: assert property (p_light_wake) else $error("light not left");
  property p_light_rst;
    light_sleep && rst_pin |=> core_run && ram_block;
  endproperty
  a_light_rst: assert property (p_light_rst) else $error("ram not blocked");
  property p_irq_wake;
    wake_irq |-> core_run && !deep_sleep && !sfr_reinit && osc_run;
  endproperty
  a_irq_wake: assert property (p_irq_wake) else $error("irq wake wrong");
  property p_emul_pins;
    emul_mode |-> port0_float && port_weak_pu && !ale_oe && !prog_store_strobe_oe
      && ale_weak_pu && osc_run && !core_run;
  endproperty
  a_emul_pins: assert property (p_emul_pins) else $error("emulation pins wrong");
  property p_emul_stay;
    emul_mode && !rst_pin && !chip_reset |=> emul_mode;
  endproperty
  a_emul_stay: assert property (p_emul_stay) else $error("emulation left");
  property p_rst_qual;
    hold_q == 6'(RST_HOLD_CLKS) |-> ##[0:3] chip_reset;
  endproperty
  a_rst_qual: assert property (p_rst_qual) else $error("no chip reset");
endmodule : lpm_ctrl_asserts

// [verif/lpm_board.sv]
// Board model: reset source, interrupt pins and emulator strap.
// Assumes bench commands; pins change just after ref_clk rises.
`timescale 1ns/1ns
module lpm_board (
  // Clock
  input  wire logic       ref_clk,
  // Commands
  input  wire logic       want_rst,
  input  wire logic [1:0] want_irq,
  input  wire logic       want_emul,
  // Device drive
  input  wire logic       ale_out,
  input  wire logic       ale_oe,
  input  wire logic       ale_weak_pu,
  input  wire logic       ps_out,
  input  wire logic       ps_oe,
  input  wire logic       ps_weak_pu,
  // Board pins
  output logic            rst_pin,
  output logic            ext_irq_a_n,
  output logic            ext_irq_b_n,
  output logic            ale_pin_in,
  output logic            prog_store_strobe_in
);
  // Sources held as commanded until the bench changes the command
  always @(posedge ref_clk) begin
    rst_pin <= want_rst;
    ext_irq_a_n <= !want_irq[0];
    ext_irq_b_n <= !want_irq[1];
  end
  // Strap holds latch strobe low; undriven pins read high with a weak pull-up, else float away from last value
  assign ale_pin_in = !want_emul && (ale_oe ? ale_out : (ale_weak_pu | !ale_out));
  assign prog_store_strobe_in = ps_oe ? ps_out : (ps_weak_pu | !ps_out);
endmodule : lpm_board

// [verif/lpm_ctrl_tb.sv]
// Bench for the mode controller with board model and bound checker.
// Assumes a shortened oscillator wait of 8 cycles.
`timescale 1ns/1ns
module lpm_ctrl_tb;
  logic ref_clk, rst = 1'b1, clk_en = 1'b1;
  logic light_req = 1'b0, deep_req = 1'b0, irq_pending = 1'b0, return_from_handler = 1'b0;
  logic ext_code = 1'b0, ale_disable = 1'b0, ext_irq_a_en = 1'b0, ext_irq_b_en = 1'b0;
  logic ext_irq_a_level = 1'b0, ext_irq_b_level = 1'b0;
  logic core_ale = 1'b1, core_prog_store = 1'b1, core_p2_addr = 1'b1;
  logic want_rst = 1'b0, want_emul = 1'b0;
  logic [1:0] want_irq = 2'b00;
  logic rst_pin, ext_irq_a_n, ext_irq_b_n, ale_pin_in, prog_store_strobe_in;
  logic core_run, osc_run, chip_reset, sfr_reinit, ram_block, wake_irq, resume_next;
  logic light_sleep, deep_sleep, emul_mode, ale_out, ale_oe, ale_weak_pu;
  logic prog_store_strobe_out, prog_store_strobe_oe, prog_store_strobe_weak_pu;
  logic port0_float, port2_addr_sel, port_weak_pu;
  int   failures = 0, checks_done = 0, cyc = 0;
  lpm_ctrl #(.OSC_WAIT_CLKS(8)) u_lpm_ctrl (.*);
  lpm_board u_lpm_board (.ref_clk(ref_clk), .want_rst(want_rst), .want_irq(want_irq),
    .want_emul(want_emul), .ale_out(ale_out), .ale_oe(ale_oe), .ale_weak_pu(ale_weak_pu),
    .ps_out(prog_store_strobe_out), .ps_oe(prog_store_strobe_oe),
    .ps_weak_pu(prog_store_strobe_weak_pu), .rst_pin(rst_pin), .ext_irq_a_n(ext_irq_a_n),
    .ext_irq_b_n(ext_irq_b_n), .ale_pin_in(ale_pin_in), .prog_store_strobe_in(prog_store_strobe_in));
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  task automatic report_and_stop();
    if (failures == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      failures++;
      report_and_stop();
    end
  end
  task automatic chk(input logic s, input logic e);
    checks_done++;
    if (s !== e) begin
      failures++;
      $display("mismatch at %0t: got %b want %b", $time, s, e);
    end
  endtask : chk
  task automatic wt(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : wt
  task automatic req(input logic l, input logic d);
    @(posedge ref_clk);
    light_req <= l;
    deep_req <= d;
    @(posedge ref_clk);
    light_req <= 1'b0;
    deep_req <= 1'b0;
    wt(1);
  endtask : req
  task automatic rst_cycle();
    @(posedge ref_clk);
    want_rst <= 1'b1;
    for (int i = 0; i < 60 && chip_reset !== 1'b1; i++) wt(1);
    chk(chip_reset, 1'b1);
    chk(sfr_reinit, 1'b1);
    @(posedge ref_clk);
    want_rst <= 1'b0;
    wt(4);
  endtask : rst_cycle
  task automatic t_light(input logic ec);
    @(posedge ref_clk);
    ext_code <= ec;
    ale_disable <= 1'b1;
    req(1'b1, 1'b0);
    wt(3);
    chk(light_sleep, 1'b1);
    chk(core_run, 1'b0);
    chk(ale_out & prog_store_strobe_out, 1'b1);
    chk(port0_float, ec);
    chk(port2_addr_sel, ec);
    chk(ale_weak_pu, 1'b0);
    @(posedge ref_clk);
    irq_pending <= 1'b1;
    @(posedge ref_clk);
    irq_pending <= 1'b0;
    wt(1);
    chk(light_sleep, 1'b0);
    chk(core_run, 1'b1);
  endtask : t_light
  task automatic t_light_rst();
    req(1'b1, 1'b0); // Core pins left idle after the request
    @(posedge ref_clk);
    want_rst <= 1'b1;
    for (int i = 0; i < 5 && ram_block !== 1'b1; i++) wt(1);
    chk(ram_block, 1'b1);
    chk(core_run, 1'b1);
    rst_cycle();
  endtask : t_light_rst
  task automatic t_deep_irq();
    @(posedge ref_clk);
    ext_code <= 1'b1;
    {ext_irq_a_en, ext_irq_b_en, ext_irq_a_level, ext_irq_b_level} <= 4'hf;
    req(1'b1, 1'b1);
    chk(deep_sleep, 1'b1);
    chk(light_sleep, 1'b0);
    chk(osc_run | core_run, 1'b0);
    chk(ale_out | prog_store_strobe_out | port2_addr_sel, 1'b0);
    chk(port0_float, 1'b1);
    @(posedge ref_clk);
    want_irq <= 2'b01;
    wt(4);
    chk(osc_run, 1'b1);
    wt(12);
    chk(deep_sleep, 1'b1);
    chk(sfr_reinit, 1'b0);
    @(posedge ref_clk);
    want_irq <= 2'b00;
    for (int i = 0; i < 8 && wake_irq !== 1'b1; i++) wt(1);
    chk(wake_irq & core_run, 1'b1);
    chk(sfr_reinit, 1'b0);
    @(posedge ref_clk);
    return_from_handler <= 1'b1;
    @(posedge ref_clk);
    return_from_handler <= 1'b0;
    wt(1);
    chk(resume_next, 1'b1);
  endtask : t_deep_irq
  task automatic t_deep_rst();
    @(posedge ref_clk);
    {ext_irq_a_en, ext_irq_b_level} <= 2'b00;
    req(1'b0, 1'b1);
    @(posedge ref_clk);
    want_irq <= 2'b11;
    wt(12);
    chk(osc_run, 1'b0);
    @(posedge ref_clk);
    want_irq <= 2'b00;
    rst_cycle();
    chk(deep_sleep, 1'b0);
    chk(core_run, 1'b1);
  endtask : t_deep_rst
  task automatic t_emul();
    @(posedge ref_clk);
    want_emul <= 1'b1;
    rst_cycle();
    for (int i = 0; i < 10 && emul_mode !== 1'b1; i++) wt(1);
    @(posedge ref_clk);
    want_emul <= 1'b0;
    wt(1);
    chk(emul_mode & port0_float & port_weak_pu & osc_run, 1'b1);
    chk(ale_weak_pu & prog_store_strobe_weak_pu, 1'b1);
    chk(ale_oe | prog_store_strobe_oe | core_run, 1'b0);
    req(1'b1, 1'b0);
    chk(light_sleep, 1'b0);
    @(posedge ref_clk);
    want_rst <= 1'b1;
    wt(10);
    @(posedge ref_clk);
    want_rst <= 1'b0;
    wt(3);
    chk(chip_reset, 1'b0);
    chk(emul_mode, 1'b1);
    rst_cycle();
    chk(emul_mode, 1'b0);
  endtask : t_emul
  initial begin
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    wt(1);
    chk(core_run & osc_run & ale_oe & prog_store_strobe_oe, 1'b1);
    chk(emul_mode | light_sleep | deep_sleep | chip_reset, 1'b0);
    t_light(1'b0);
    t_light(1'b1);
    t_light_rst();
    t_deep_irq();
    t_deep_rst();
    t_emul();
    report_and_stop();
  end
endmodule : lpm_ctrl_tb
bind lpm_ctrl lpm_ctrl_asserts u_lpm_ctrl_asserts (.*);
